// >>> hw/abu_addr_match.sv
// comparator that qualifies program-counter addresses against the match value
`timescale 1ns/100ps

module abu_addr_match #(
    parameter int AW = 16
) (
    input  wire logic [AW-1:0] bus_addr,
    input  wire logic          pc_cycle,
    input  wire logic [AW-1:0] match_addr,
    input  wire logic          enable,
    output logic               hit
);

    // only fetches driven by the program counter count; data cycles never hit
    assign hit = enable && pc_cycle && (bus_addr == match_addr);

endmodule : abu_addr_match

// >>> hw/abu_pkg.sv
// types shared by the breakpoint unit
package abu_pkg;

    // ==========================================================
    // break sequencing
    typedef enum logic [1:0] {
        ABU_IDLE    = 2'b00,
        ABU_PENDING = 2'b01,
        ABU_ACTIVE  = 2'b10
    } abu_state_e;

    // ==========================================================
    // complete state of the top module
    typedef struct packed {
        logic        break_enable_bit;
        logic        break_active_flag;
        logic [7:0]  match_high;
        logic [7:0]  match_low;
        logic        stop_wait_exit_flag;
        logic        clear_flag_enable;
        abu_state_e  phase;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  irq_status;
        logic [1:0]  irq_enable;
        logic [15:0] vector;
        logic [7:0]  opcode;
    } abu_state_s;

endpackage : abu_pkg

// >>> hw/abu_regs.svh
// register offsets, field positions, reset values and fixed codes of the breakpoint unit
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH

// ==========================================================
// byte offsets on the register bus, one aligned word each
`define ABU_OFS_CTRL_STATUS  6'h00
`define ABU_OFS_MATCH_HIGH   6'h04
`define ABU_OFS_MATCH_LOW    6'h08
`define ABU_OFS_WAKE_STATUS  6'h0C
`define ABU_OFS_FLAG_CLEAR   6'h10
`define ABU_OFS_IRQ_STATUS   6'h14
`define ABU_OFS_IRQ_ENABLE   6'h18
`define ABU_OFS_IRQ_CLEAR    6'h1C
`define ABU_OFS_UNIT_STATE   6'h20

// ==========================================================
// field positions
`define ABU_BIT_BREAK_ENABLE 7
`define ABU_BIT_BREAK_ACTIVE 6
`define ABU_BIT_STOP_WAIT    1
`define ABU_BIT_CLEAR_ENABLE 7
`define ABU_IRQ_ENTRY        0
`define ABU_IRQ_WAKE         1

// ==========================================================
// reset values and fixed codes
`define ABU_RST_BYTE         8'h00
`define ABU_VECTOR_USER      16'hFFFC
`define ABU_VECTOR_MONITOR   16'hFEFC
`define ABU_OPCODE_SWI       8'h83
`define ABU_OPCODE_RTI       8'h80

`endif

// >>> hw/abu_unit.sv
// address breakpoint unit: match logic, break sequencing and register slave
`timescale 1ns/100ps
`include "abu_regs.svh"

// Operation
// - address equal to match value with breaks enabled raises the breakpoint request.
// - only program-counter addresses are compared; other bus cycles never match.
// - after the current instruction the core is handed the swi opcode.
// - break vector is FFFC in user mode, FEFC in monitor mode.
// - a match on an instruction's last cycle forces entry in that cycle.
// - enable bit 7 permits 16-bit match breaks, blocks them when zero, resets clear.
// - active flag set by match, readable, writable, cleared by writing zero or reset.
// - writing one to the active flag starts a break like a match.
// - match address held as high and low bytes, both zero after reset.
// - a return-from-interrupt inside the break ends the break state.
// - while the break is active the timer counter is held.
// - watchdog disabled during the break while the test voltage is present.
// - during break, peripheral flags clear only when the clear-flag enable is one.
// - a break in stop mode wakes the device and sets the stop/wait flag.
// - stop/wait flag reads one after a break exit, cleared by zero or reset.
// - matching keeps running in wait mode so a match can end wait.
module abu_unit (
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              CE,
    // register bus
    input  wire logic [5:0]        AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    output logic [31:0]            AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    output logic                   IRQ,
    // core side
    input  wire logic [15:0]       CPU_ADDR,
    input  wire logic              CPU_PC_CYCLE,
    input  wire logic              CPU_LAST_CYCLE,
    input  wire logic              CPU_OPCODE_LOAD,
    input  wire logic [7:0]        CPU_OPCODE,
    input  wire logic              MONITOR_MODE,
    input  wire logic              STOP_MODE,
    input  wire logic              WAIT_MODE,
    input  wire logic              HIGH_TEST_VOLTAGE,
    // toward the system integration logic
    output logic                   BREAKPOINT_REQUEST,
    output logic                   FORCE_OPCODE,
    output logic [7:0]             FORCED_OPCODE,
    output logic [15:0]            BREAK_VECTOR,
    output logic                   LOW_POWER_EXIT,
    output logic                   BREAK_STATE,
    output abu_pkg::abu_state_e    BREAK_PHASE,
    output logic                   TIMER_HOLD,
    output logic                   WATCHDOG_DISABLE,
    output logic                   FLAG_CLEAR_ALLOW
);
    import abu_pkg::*;

    abu_state_s s;
    abu_state_s next_s;

    logic hit;
    logic sw_request;
    logic new_request;
    logic boundary;
    logic take;
    logic rti_seen;
    logic access;
    logic do_write;
    logic do_read;

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h00_0000, b};
    endfunction : byte_word

    // stop and wait both count as an instruction boundary and as a wake event
    function automatic logic low_power(input logic stop_in, input logic wait_in);
        low_power = stop_in || wait_in;
    endfunction : low_power

    // ==========================================================
    // address compare
    abu_addr_match #(
        .AW(16)
    ) u_match (
        .bus_addr   (CPU_ADDR),
        .pc_cycle   (CPU_PC_CYCLE),
        .match_addr ({s.match_high, s.match_low}),
        .enable     (s.break_enable_bit),
        .hit        (hit)
    );

    // ==========================================================
    // bus handshake: one wait cycle, then the access completes
    assign access   = (AVS_READ || AVS_WRITE) && CE;
    assign do_write = AVS_WRITE && s.ack && CE;
    assign do_read  = AVS_READ && !s.ack && CE;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s.ack;
    assign AVS_READDATA    = s.rdata;

    assign sw_request = do_write && (AVS_ADDRESS == `ABU_OFS_CTRL_STATUS)
                        && AVS_WRITEDATA[`ABU_BIT_BREAK_ACTIVE];

    // matching is not gated by wait mode, so a match can end it
    assign new_request = (s.phase == ABU_IDLE) && (hit || sw_request);
    // in stop or wait no instruction runs, so the request is taken at once
    assign boundary = CPU_LAST_CYCLE || low_power(STOP_MODE, WAIT_MODE);
    assign take = ((s.phase == ABU_PENDING) || new_request) && boundary && CE;
    assign rti_seen = (s.phase == ABU_ACTIVE) && CPU_OPCODE_LOAD
                      && (CPU_OPCODE == `ABU_OPCODE_RTI);

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.ack = access && !s.ack;
        next_s.vector = MONITOR_MODE ? `ABU_VECTOR_MONITOR : `ABU_VECTOR_USER;
        next_s.opcode = `ABU_OPCODE_SWI;

        if (do_read) begin
            unique case (AVS_ADDRESS)
                `ABU_OFS_CTRL_STATUS: next_s.rdata = byte_word({s.break_enable_bit,
                                                    s.break_active_flag, 6'h00});
                `ABU_OFS_MATCH_HIGH:  next_s.rdata = byte_word(s.match_high);
                `ABU_OFS_MATCH_LOW:   next_s.rdata = byte_word(s.match_low);
                `ABU_OFS_WAKE_STATUS: next_s.rdata = byte_word({6'h00,
                                                    s.stop_wait_exit_flag, 1'b0});
                `ABU_OFS_FLAG_CLEAR:  next_s.rdata = byte_word({s.clear_flag_enable,
                                                    7'h00});
                `ABU_OFS_IRQ_STATUS:  next_s.rdata = byte_word({6'h00, s.irq_status});
                `ABU_OFS_IRQ_ENABLE:  next_s.rdata = byte_word({6'h00, s.irq_enable});
                `ABU_OFS_UNIT_STATE:  next_s.rdata = byte_word({6'h00, s.phase});
                default:              next_s.rdata = 32'h0000_0000;
            endcase
        end

        if (do_write) begin
            unique case (AVS_ADDRESS)
                `ABU_OFS_CTRL_STATUS: begin
                    next_s.break_enable_bit  = AVS_WRITEDATA[`ABU_BIT_BREAK_ENABLE];
                    next_s.break_active_flag = AVS_WRITEDATA[`ABU_BIT_BREAK_ACTIVE];
                end
                `ABU_OFS_MATCH_HIGH: next_s.match_high = AVS_WRITEDATA[7:0];
                `ABU_OFS_MATCH_LOW:  next_s.match_low  = AVS_WRITEDATA[7:0];
                `ABU_OFS_WAKE_STATUS: begin
                    // writing one has no effect; only zero clears
                    if (!AVS_WRITEDATA[`ABU_BIT_STOP_WAIT]) begin
                        next_s.stop_wait_exit_flag = 1'b0;
                    end
                end
                `ABU_OFS_FLAG_CLEAR: next_s.clear_flag_enable =
                                         AVS_WRITEDATA[`ABU_BIT_CLEAR_ENABLE];
                `ABU_OFS_IRQ_ENABLE: next_s.irq_enable = AVS_WRITEDATA[1:0];
                `ABU_OFS_IRQ_CLEAR:  next_s.irq_status = s.irq_status & ~AVS_WRITEDATA[1:0];
                default: begin
                end
            endcase
        end

        // hardware sets come last so they win over a clear in the same cycle
        if (hit && CE) begin
            next_s.break_active_flag = 1'b1;
        end

        unique case (s.phase)
            ABU_IDLE: begin
                if (take) begin
                    next_s.phase = ABU_ACTIVE;
                end else if (new_request && CE) begin
                    next_s.phase = ABU_PENDING;
                end
            end
            ABU_PENDING: begin
                if (take) begin
                    next_s.phase = ABU_ACTIVE;
                end
            end
            ABU_ACTIVE: begin
                if (rti_seen && CE) begin
                    next_s.phase = ABU_IDLE;
                end
            end
            default: next_s.phase = ABU_IDLE;
        endcase

        if (take) begin
            next_s.irq_status[`ABU_IRQ_ENTRY] = 1'b1;
            if (low_power(STOP_MODE, WAIT_MODE)) begin
                next_s.stop_wait_exit_flag        = 1'b1;
                next_s.irq_status[`ABU_IRQ_WAKE]  = 1'b1;
            end
        end
    end

    // ==========================================================
    // state register; clock enable low freezes everything
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s <= '{break_enable_bit: 1'b0, break_active_flag: 1'b0,
                   match_high: `ABU_RST_BYTE, match_low: `ABU_RST_BYTE,
                   stop_wait_exit_flag: 1'b0, clear_flag_enable: 1'b0,
                   phase: ABU_IDLE, ack: 1'b0, rdata: 32'h0000_0000,
                   irq_status: 2'b00, irq_enable: 2'b00,
                   vector: `ABU_VECTOR_USER, opcode: `ABU_OPCODE_SWI};
        end else if (CE) begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs toward the core and the system integration logic
    assign BREAKPOINT_REQUEST = (s.phase == ABU_PENDING) || new_request;
    assign FORCE_OPCODE       = take;
    assign FORCED_OPCODE      = s.opcode;
    assign BREAK_VECTOR       = s.vector;
    assign LOW_POWER_EXIT     = take && low_power(STOP_MODE, WAIT_MODE);
    assign BREAK_STATE        = (s.phase == ABU_ACTIVE);
    assign BREAK_PHASE        = s.phase;
    assign TIMER_HOLD         = (s.phase == ABU_ACTIVE);
    assign WATCHDOG_DISABLE   = (s.phase == ABU_ACTIVE) && HIGH_TEST_VOLTAGE;
    assign FLAG_CLEAR_ALLOW   = (s.phase != ABU_ACTIVE) || s.clear_flag_enable;
    assign IRQ                = |(s.irq_status & s.irq_enable);

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    match_request_a: assert property (hit |-> BREAKPOINT_REQUEST || s.phase == ABU_ACTIVE)
        else $error("enabled match did not raise the breakpoint request");

    pc_only_a: assert property (!CPU_PC_CYCLE |-> !hit)
        else $error("non program counter cycle produced a match");

    entry_force_a: assert property (CE && s.phase == ABU_PENDING && CPU_LAST_CYCLE
                                    |-> FORCE_OPCODE ##1 BREAK_STATE)
        else $error("pending break not entered at the instruction boundary");

    vector_page_a: assert property (CE ##1 $stable(MONITOR_MODE) |->
                                    BREAK_VECTOR == (MONITOR_MODE ? `ABU_VECTOR_MONITOR
                                                                  : `ABU_VECTOR_USER))
        else $error("break vector does not follow the mode");

    last_cycle_a: assert property (CE && s.phase == ABU_IDLE && hit && CPU_LAST_CYCLE
                                   |-> FORCE_OPCODE ##1 s.phase == ABU_ACTIVE)
        else $error("match on last cycle did not enter at once");

    disabled_block_a: assert property (!s.break_enable_bit |-> !hit)
        else $error("match reported while breaks disabled");

    flag_set_a: assert property (CE && hit |=> s.break_active_flag)
        else $error("active flag not set by a match");

    sw_start_a: assert property (CE && sw_request && s.phase == ABU_IDLE
                                 |=> s.phase != ABU_IDLE)
        else $error("software write of one did not start a break");

    rti_exit_a: assert property (CE && rti_seen |=> s.phase == ABU_IDLE)
        else $error("return from interrupt did not end the break");

    timer_hold_a: assert property (BREAK_STATE |-> TIMER_HOLD
                                   && (WATCHDOG_DISABLE == HIGH_TEST_VOLTAGE))
        else $error("timer or watchdog control wrong during break");

    flag_guard_a: assert property (BREAK_STATE && !s.clear_flag_enable |-> !FLAG_CLEAR_ALLOW)
        else $error("peripheral flag clearing allowed in break without enable");

    wake_flag_a: assert property (LOW_POWER_EXIT |=> s.stop_wait_exit_flag)
        else $error("stop or wait exit did not set the flag");

    pending_take_a: assert property (CE && s.phase == ABU_PENDING && WAIT_MODE
                                     |-> FORCE_OPCODE && LOW_POWER_EXIT)
        else $error("pending break not taken in wait mode");

    // ==========================================================
    // register bus and clock enable
    logic ctrl_write;
    assign ctrl_write = do_write && (AVS_ADDRESS == `ABU_OFS_CTRL_STATUS);

    bus_one_wait_a: assert property (CE && AVS_WAITREQUEST |=> s.ack)
        else $error("bus access not answered after one wait cycle");

    bus_release_a: assert property (CE && s.ack |=> !s.ack)
        else $error("bus acknowledge held for more than one cycle");

    // a frozen cycle must not even move the bus handshake
    ce_freeze_a: assert property (!CE |=> $stable(s))
        else $error("state changed while the clock enable was low");

    // ==========================================================
    // register fields
    enable_set_a: assert property (CE && ctrl_write
                                   && AVS_WRITEDATA[`ABU_BIT_BREAK_ENABLE]
                                   |=> s.break_enable_bit)
        else $error("break enable not set by a write of one");

    enable_clear_a: assert property (CE && ctrl_write
                                     && !AVS_WRITEDATA[`ABU_BIT_BREAK_ENABLE]
                                     |=> !s.break_enable_bit)
        else $error("break enable not cleared by a write of zero");

    flag_clear_a: assert property (CE && ctrl_write && !hit
                                   && !AVS_WRITEDATA[`ABU_BIT_BREAK_ACTIVE]
                                   |=> !s.break_active_flag)
        else $error("active flag not cleared by a write of zero");

    wake_clear_a: assert property (CE && do_write && !take
                                   && AVS_ADDRESS == `ABU_OFS_WAKE_STATUS
                                   && !AVS_WRITEDATA[`ABU_BIT_STOP_WAIT]
                                   |=> !s.stop_wait_exit_flag)
        else $error("stop or wait flag not cleared by a write of zero");

    // ==========================================================
    // break sequencing outputs
    phase_legal_a: assert property (s.phase inside {ABU_IDLE, ABU_PENDING, ABU_ACTIVE})
        else $error("break phase holds an unused code");

    force_pulse_a: assert property (FORCE_OPCODE |=> !FORCE_OPCODE)
        else $error("forced opcode request lasted more than one cycle");

    forced_code_a: assert property (FORCED_OPCODE == `ABU_OPCODE_SWI)
        else $error("forced opcode is not the software interrupt code");

    no_request_a: assert property (BREAK_STATE |-> !BREAKPOINT_REQUEST)
        else $error("breakpoint request raised inside the break state");

    break_hold_a: assert property (BREAK_STATE && !rti_seen |=> BREAK_STATE)
        else $error("break state left without a return from interrupt");

    wake_cause_a: assert property (LOW_POWER_EXIT |-> STOP_MODE || WAIT_MODE)
        else $error("wake request raised outside stop or wait");

    entry_irq_a: assert property (FORCE_OPCODE |=> s.irq_status[`ABU_IRQ_ENTRY])
        else $error("break entry did not set its interrupt status bit");

    // outside a break the timer, watchdog and peripheral flags run freely
    idle_outputs_a: assert property (!BREAK_STATE |-> !TIMER_HOLD
                                     && !WATCHDOG_DISABLE && FLAG_CLEAR_ALLOW)
        else $error("break controls active outside the break state");

endmodule : abu_unit

// >>> testbench/abu_core_model.sv
// core-side partner model: steps instructions and answers forced opcode loads
`timescale 1ns/100ps

module abu_core_model (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        run,
    input  wire logic        short_ins,
    input  wire logic        rti_req,
    input  wire logic        force_opcode,
    input  wire logic [7:0]  forced_opcode,
    output logic      [15:0] addr,
    output logic             pc_cycle,
    output logic             last_cycle,
    output logic             opcode_load,
    output logic      [7:0]  opcode
);
    logic [15:0] pc;
    logic        ph;
    logic        halt;

    // ==========================================================
    // instruction stepping
    // a two-cycle instruction fetches at pc, then reads data at pc + 0x100
    assign pc_cycle   = run & !halt & !ph;
    assign last_cycle = run & !halt & (ph | short_ins);
    // idle bus shows the inverted pc so a stale value cannot match by chance
    assign addr       = (!run || halt) ? ~pc : (ph ? pc + 16'h0100 : pc);

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pc          <= 16'h0000;
            ph          <= 1'b0;
            halt        <= 1'b0;
            opcode_load <= 1'b0;
            opcode      <= 8'h00;
        end else begin
            opcode_load <= 1'b0;
            if (force_opcode) begin
                halt        <= 1'b1;
                opcode_load <= 1'b1;
                opcode      <= forced_opcode;
                pc          <= pc + 16'h0001;
                ph          <= 1'b0;
            end else if (halt && rti_req) begin
                halt        <= 1'b0;
                opcode_load <= 1'b1;
                opcode      <= 8'h80;
            end else if (!run) begin
                pc <= 16'h0000;
                ph <= 1'b0;
            end else if (!halt) begin
                ph <= !ph && !short_ins;
                if (ph || short_ins)
                    pc <= pc + 16'h0001;
            end
        end
    end
endmodule : abu_core_model

// >>> testbench/abu_unit_tb_top.sv
// self-checking bench for the breakpoint unit, driven over the register bus
`timescale 1ns/100ps
`include "abu_regs.svh"

module abu_unit_tb_top;
    import abu_pkg::*;
    localparam int LIMIT = 5000;
    logic        CLK = 1'b0, RESET_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic        MONITOR_MODE = 1'b0, STOP_MODE = 1'b0, WAIT_MODE = 1'b0, CE = 1'b1;
    logic        HIGH_TEST_VOLTAGE = 1'b0, run = 1'b0, short_ins = 1'b0, rti_req = 1'b0;
    logic [5:0]  AVS_ADDRESS = 6'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA, q;
    logic        AVS_WAITREQUEST, IRQ, CPU_PC_CYCLE, CPU_LAST_CYCLE, CPU_OPCODE_LOAD, ws;
    logic        BREAKPOINT_REQUEST, FORCE_OPCODE, LOW_POWER_EXIT, BREAK_STATE;
    logic        TIMER_HOLD, WATCHDOG_DISABLE, FLAG_CLEAR_ALLOW;
    logic [15:0] CPU_ADDR, BREAK_VECTOR;
    logic [7:0]  CPU_OPCODE, FORCED_OPCODE;
    abu_state_e  BREAK_PHASE;
    int          fails = 0, checks = 0, lat = 0, f_lat = 0, lpe_cnt = 0, cyc = 0, l0;

    always #5 CLK = ~CLK;
    // waitrequest as it stands just before the next rising edge
    always @(negedge CLK) ws = AVS_WAITREQUEST;

    abu_unit u_abu_unit (
        .CLK, .RESET_N, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_READDATA, .AVS_WAITREQUEST, .IRQ, .CPU_ADDR, .CPU_PC_CYCLE, .CPU_LAST_CYCLE,
        .CPU_OPCODE_LOAD, .CPU_OPCODE, .MONITOR_MODE, .STOP_MODE, .WAIT_MODE,
        .HIGH_TEST_VOLTAGE, .BREAKPOINT_REQUEST, .FORCE_OPCODE, .FORCED_OPCODE,
        .BREAK_VECTOR, .LOW_POWER_EXIT, .BREAK_STATE, .BREAK_PHASE, .TIMER_HOLD,
        .WATCHDOG_DISABLE, .FLAG_CLEAR_ALLOW
    );

    abu_core_model u_abu_core_model (
        .CLK, .RESET_N, .run, .short_ins, .rti_req, .force_opcode(FORCE_OPCODE),
        .forced_opcode(FORCED_OPCODE), .addr(CPU_ADDR), .pc_cycle(CPU_PC_CYCLE),
        .last_cycle(CPU_LAST_CYCLE), .opcode_load(CPU_OPCODE_LOAD), .opcode(CPU_OPCODE)
    );

    // ==========================================================
    // reporting
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // f_lat: request cycles seen before the forced load, 0 means same cycle
    always @(posedge CLK) begin
        if (FORCE_OPCODE === 1'b1)
            f_lat <= lat;
        lat <= (BREAKPOINT_REQUEST === 1'b1) ? lat + 1 : 0;
        if (LOW_POWER_EXIT === 1'b1)
            lpe_cnt <= lpe_cnt + 1;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            give_verdict();
        end
    end

    // ==========================================================
    // bus and core helpers
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITE     <= w;
        AVS_READ      <= !w;
        AVS_WRITEDATA <= {24'h00_0000, d};
        do
            @(posedge CLK);
        while (ws !== 1'b0);
        q = AVS_READDATA;
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
        #1;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h00_0000, e});
    endtask : rd

    task automatic setrun(input logic v);
        @(posedge CLK) run <= v;
        #1;
    endtask : setrun

    task automatic wait_st(input logic v);
        int n = 0;
        while (BREAK_STATE !== v && n < 200) begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk(BREAK_STATE, v);
    endtask : wait_st

    task automatic end_brk(input logic [7:0] c);
        wr(`ABU_OFS_CTRL_STATUS, c);
        @(posedge CLK) rti_req <= 1'b1;
        @(posedge CLK) rti_req <= 1'b0;
        wait_st(1'b0);
        rd(`ABU_OFS_CTRL_STATUS, c);
    endtask : end_brk

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd(6'(4 * i), 8'h00);
        chk(BREAK_VECTOR, 16'hFFFC);
        chk(FORCED_OPCODE, 8'h83);
        wr(6'h3C, 8'hFF);
        rd(6'h3C, 8'h00);
        wr(`ABU_OFS_UNIT_STATE, 8'h02);
        rd(`ABU_OFS_UNIT_STATE, 8'h00);
        wr(`ABU_OFS_MATCH_HIGH, 8'h01);
        wr(`ABU_OFS_MATCH_LOW, 8'h05);
        rd(`ABU_OFS_MATCH_HIGH, 8'h01);
        rd(`ABU_OFS_MATCH_LOW, 8'h05);
        // 0x0105 only ever shows up as a data address here
        wr(`ABU_OFS_CTRL_STATUS, 8'h80);
        setrun(1'b1);
        repeat (16) @(posedge CLK);
        setrun(1'b0);
        chk(BREAK_PHASE, ABU_IDLE);
        rd(`ABU_OFS_CTRL_STATUS, 8'h80);
        wr(`ABU_OFS_MATCH_HIGH, 8'h00);
        wr(`ABU_OFS_MATCH_LOW, 8'h04);
        wr(`ABU_OFS_CTRL_STATUS, 8'h00);
        setrun(1'b1);
        repeat (16) @(posedge CLK);
        setrun(1'b0);
        rd(`ABU_OFS_CTRL_STATUS, 8'h00);
        @(posedge CLK) HIGH_TEST_VOLTAGE <= 1'b1;
        wr(`ABU_OFS_IRQ_ENABLE, 8'h03);
        wr(`ABU_OFS_CTRL_STATUS, 8'h80);
        // a match passing while the clock enable is low leaves no trace
        @(posedge CLK) CE <= 1'b0;
        setrun(1'b1);
        repeat (16) @(posedge CLK);
        setrun(1'b0);
        @(posedge CLK) CE <= 1'b1;
        chk(BREAK_PHASE, ABU_IDLE);
        rd(`ABU_OFS_CTRL_STATUS, 8'h80);
        setrun(1'b1);
        wait_st(1'b1);
        chk(f_lat, 1);
        chk(BREAK_VECTOR, 16'hFFFC);
        chk(TIMER_HOLD, 1'b1);
        chk(WATCHDOG_DISABLE, 1'b1);
        chk(FLAG_CLEAR_ALLOW, 1'b0);
        wr(`ABU_OFS_FLAG_CLEAR, 8'h80);
        chk(FLAG_CLEAR_ALLOW, 1'b1);
        rd(`ABU_OFS_FLAG_CLEAR, 8'h80);
        rd(`ABU_OFS_CTRL_STATUS, 8'hC0);
        chk(IRQ, 1'b1);
        rd(`ABU_OFS_IRQ_STATUS, 8'h01);
        wr(`ABU_OFS_IRQ_CLEAR, 8'h01);
        chk(IRQ, 1'b0);
        wr(`ABU_OFS_FLAG_CLEAR, 8'h00);
        end_brk(8'h80);
        chk(TIMER_HOLD, 1'b0);
        setrun(1'b0);
        @(posedge CLK) HIGH_TEST_VOLTAGE <= 1'b0;
        MONITOR_MODE <= 1'b1;
        short_ins <= 1'b1;
        wr(`ABU_OFS_MATCH_LOW, 8'h02);
        setrun(1'b1);
        wait_st(1'b1);
        chk(f_lat, 0);
        chk(BREAK_VECTOR, 16'hFEFC);
        chk(WATCHDOG_DISABLE, 1'b0);
        end_brk(8'h80);
        setrun(1'b0);
        @(posedge CLK) MONITOR_MODE <= 1'b0;
        short_ins <= 1'b0;
        // software request with no instruction boundary yet must wait
        wr(`ABU_OFS_CTRL_STATUS, 8'h40);
        chk(BREAK_STATE, 1'b0);
        setrun(1'b1);
        wait_st(1'b1);
        rd(`ABU_OFS_CTRL_STATUS, 8'h40);
        end_brk(8'h00);
        setrun(1'b0);
        @(posedge CLK) STOP_MODE <= 1'b1;
        wr(`ABU_OFS_IRQ_ENABLE, 8'h00);
        l0 = lpe_cnt;
        wr(`ABU_OFS_CTRL_STATUS, 8'h40);
        wait_st(1'b1);
        chk(lpe_cnt - l0, 1);
        @(posedge CLK) STOP_MODE <= 1'b0;
        rd(`ABU_OFS_WAKE_STATUS, 8'h02);
        chk(IRQ, 1'b0);
        wr(`ABU_OFS_IRQ_ENABLE, 8'h02);
        chk(IRQ, 1'b1);
        rd(`ABU_OFS_IRQ_STATUS, 8'h03);
        wr(`ABU_OFS_IRQ_CLEAR, 8'h03);
        chk(IRQ, 1'b0);
        wr(`ABU_OFS_WAKE_STATUS, 8'h00);
        rd(`ABU_OFS_WAKE_STATUS, 8'h00);
        end_brk(8'h00);
        // pending software break is taken once wait mode begins
        wr(`ABU_OFS_CTRL_STATUS, 8'h40);
        chk(BREAK_PHASE, ABU_PENDING);
        @(posedge CLK) WAIT_MODE <= 1'b1;
        wait_st(1'b1);
        end_brk(8'h00);
        wr(`ABU_OFS_MATCH_LOW, 8'h03);
        wr(`ABU_OFS_CTRL_STATUS, 8'h80);
        l0 = lpe_cnt;
        setrun(1'b1);
        wait_st(1'b1);
        chk(lpe_cnt - l0, 1);
        rd(`ABU_OFS_WAKE_STATUS, 8'h02);
        @(posedge CLK) WAIT_MODE <= 1'b0;
        end_brk(8'h80);
        setrun(1'b0);
        give_verdict();
    end
endmodule : abu_unit_tb_top
